// ==== inc/integrity_pkg.sv ====
// constants, register layout and types of the system integrity monitor
package integrity_pkg;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_OUT_MIN_NS = 20000;
	localparam int RST_OUT_CYC = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DELAY_SHORT_CYC = 256;
	localparam int DELAY_LONG_CYC = 4096;
	localparam int CNT_W = 13;
	// ============================================================
	// register map (byte addresses)
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ICS_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] OPT_OFFSET = 12'h004;
	localparam logic [7:0] ICS_RESET = 8'h00;
	// integrity_control_status fields
	localparam int SRC_SEL_BIT = 7;
	localparam int WARN_IE_BIT = 6;
	localparam int WARN_FLAG_BIT = 5;
	localparam int UVD_RF_BIT = 4;
	localparam int CLK_IE_BIT = 2;
	localparam int BACKUP_FLAG_BIT = 1;
	localparam int WDG_RF_BIT = 0;
	// option status fields
	localparam int OPT_UVD_EN_BIT = 0;
	localparam int OPT_LONG_BIT = 1;
	localparam int OPT_PLL_BIT = 2;
	localparam int OPT_GUARD_BIT = 3;
	localparam int OPT_LVL_LSB = 4;
	localparam int OPT_LINE_BIT = 6;
	// ============================================================
	// synchronised input vector
	localparam int SY_BELOW_RISE = 0;
	localparam int SY_BELOW_FALL = 1;
	localparam int SY_WARN_SUPPLY = 2;
	localparam int SY_WARN_SENSE = 3;
	localparam int SY_OSC_LOST = 4;
	localparam int SY_LINE = 5;
	localparam int SY_UVD_EN = 6;
	localparam int SY_LONG = 7;
	localparam int SY_PLL = 8;
	localparam int SY_GUARD = 9;
	localparam int SY_LVL = 10;
	localparam int SY_W = 12;
	// ============================================================
	// reset sequencer states
	typedef enum logic [1:0] {
		ST_UVD_RESET = 2'b00,
		ST_WDG_RESET = 2'b01,
		ST_DELAY = 2'b10,
		ST_RUN = 2'b11
	} seq_state_t;
endpackage : integrity_pkg

// ==== hw/sync_2ff.sv ====
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// first stage read only by second stage
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule : sync_2ff
`default_nettype wire

// ==== hw/system_integrity_monitor.sv ====
// reset line sequencer, supply warning and clock guard with APB registers
`timescale 1ns/100ps
`default_nettype none
module system_integrity_monitor
	import integrity_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// analog comparators and detectors
	input wire logic below_rise_i,
	input wire logic below_fall_i,
	input wire logic warn_supply_i,
	input wire logic warn_sense_i,
	input wire logic osc_lost_i,
	// option straps
	input wire logic opt_uvd_enable_i,
	input wire logic opt_long_delay_i,
	input wire logic opt_pll_enable_i,
	input wire logic opt_guard_enable_i,
	input wire logic [1:0] opt_uvd_level_i,
	// cpu side
	input wire logic wdg_underflow_i,
	input wire logic cpu_wait_i,
	input wire logic cpu_halt_i,
	input wire logic warn_isr_enter_i,
	input wire logic irq_mask_i,
	// open-drain reset line
	input wire logic rst_line_i,
	output logic rst_line_o,
	output logic rst_line_oe_o,
	// clock and analog control, interrupts and wake
	output logic [1:0] uvd_level_o,
	output logic backup_osc_en_o,
	output logic cpu_clk_backup_o,
	output logic glitch_filter_en_o,
	output logic warn_irq_o,
	output logic clk_fail_irq_o,
	output logic wake_o
);
	// ============================================================
	// state
	typedef struct packed {
		seq_state_t st;
		logic [CNT_W-1:0] cnt;
		logic src_sel;
		logic warn_ie;
		logic warn_flag;
		logic uvd_rf;
		logic clk_ie;
		logic backup_flag;
		logic wdg_rf;
		logic backup_sel;
		logic warn_pend;
		logic [7:0] rdata;
		logic rd_err;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [SY_W-1:0] sy;
	logic uvd_en;
	logic guard_en;
	logic [CNT_W-1:0] delay_cyc;
	logic uvd_trip;
	logic warn_raw;
	logic acc;
	logic wr;
	logic rd;
	logic hit_ics;
	logic hit_opt;
	logic [7:0] ics_val;
	logic [7:0] opt_val;
	logic warn_req;
	logic clk_req;

	// ============================================================
	// input synchronisers
	sync_2ff #(.W(SY_W)) u_sync (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.async_i({opt_uvd_level_i, opt_guard_enable_i, opt_pll_enable_i, opt_long_delay_i,
			opt_uvd_enable_i, rst_line_i, osc_lost_i, warn_sense_i, warn_supply_i,
			below_fall_i, below_rise_i}),
		.sync_o(sy)
	);

	// ============================================================
	// decode and helpers
	assign uvd_en = sy[SY_UVD_EN];
	assign guard_en = sy[SY_GUARD];
	assign delay_cyc = sy[SY_LONG] ? CNT_W'(DELAY_LONG_CYC) : CNT_W'(DELAY_SHORT_CYC);
	// rising threshold in the undervoltage reset state, falling threshold in every other state
	assign uvd_trip = uvd_en && ((s_reg.st == ST_UVD_RESET) ? sy[SY_BELOW_RISE]
		: sy[SY_BELOW_FALL]);
	assign warn_raw = uvd_en && (s_reg.src_sel ? sy[SY_WARN_SENSE]
		: sy[SY_WARN_SUPPLY]);
	assign acc = psel_i && penable_i;
	assign wr = acc && pwrite_i;
	assign rd = acc && !pwrite_i;
	assign hit_ics = (paddr_i == ICS_OFFSET);
	assign hit_opt = (paddr_i == OPT_OFFSET);

	// register images
	always_comb begin
		ics_val = 8'h00;
		ics_val[SRC_SEL_BIT] = s_reg.src_sel;
		ics_val[WARN_IE_BIT] = s_reg.warn_ie;
		ics_val[WARN_FLAG_BIT] = s_reg.warn_flag;
		ics_val[UVD_RF_BIT] = s_reg.uvd_rf;
		ics_val[CLK_IE_BIT] = s_reg.clk_ie;
		ics_val[BACKUP_FLAG_BIT] = s_reg.backup_flag;
		ics_val[WDG_RF_BIT] = s_reg.wdg_rf;
		opt_val = 8'h00;
		opt_val[OPT_UVD_EN_BIT] = sy[SY_UVD_EN];
		opt_val[OPT_LONG_BIT] = sy[SY_LONG];
		opt_val[OPT_PLL_BIT] = sy[SY_PLL];
		opt_val[OPT_GUARD_BIT] = sy[SY_GUARD];
		opt_val[OPT_LVL_LSB +: 2] = sy[SY_LVL +: 2];
		opt_val[OPT_LINE_BIT] = sy[SY_LINE];
	end

	// ============================================================
	// next state
	always_comb begin
		s_next = s_reg;
		// reset sequencer
		case (s_reg.st)
			ST_UVD_RESET: begin
				s_next.cnt = '0;
				if (!uvd_trip) begin
					s_next.st = ST_DELAY;
				end
			end
			ST_WDG_RESET: begin
				s_next.cnt = s_reg.cnt + CNT_W'(1);
				if (uvd_trip) begin
					s_next.st = ST_UVD_RESET;
				end else if (s_reg.cnt == CNT_W'(RST_OUT_CYC - 1)) begin
					s_next.st = ST_DELAY;
					s_next.cnt = '0;
				end
			end
			ST_DELAY: begin
				s_next.cnt = s_reg.cnt + CNT_W'(1);
				if (uvd_trip) begin
					s_next.st = ST_UVD_RESET;
				end else if (s_reg.cnt == delay_cyc - CNT_W'(1)) begin
					s_next.st = ST_RUN;
					s_next.cnt = '0;
				end
			end
			ST_RUN: begin
				s_next.cnt = '0;
				if (uvd_trip) begin
					s_next.st = ST_UVD_RESET;
				end else if (wdg_underflow_i) begin
					s_next.st = ST_WDG_RESET;
				end
			end
			default: begin
				s_next.st = ST_UVD_RESET;
			end
		endcase
		// reset source flags, set only by a real trip and not by a plain system reset
		if (s_reg.st == ST_UVD_RESET && uvd_trip) begin
			s_next.uvd_rf = 1'b1;
			s_next.wdg_rf = 1'b0;
		end else if (s_reg.st == ST_WDG_RESET) begin
			s_next.wdg_rf = 1'b1;
		end
		// clock guard, off in halt
		s_next.backup_sel = guard_en && !cpu_halt_i && sy[SY_OSC_LOST];
		// register frozen in halt except the reset source flags, config kept for wake
		if (!cpu_halt_i) begin
			s_next.warn_flag = warn_raw;
			if (wr && hit_ics) begin
				s_next.src_sel = pwdata_i[SRC_SEL_BIT];
				s_next.warn_ie = pwdata_i[WARN_IE_BIT];
				s_next.clk_ie = pwdata_i[CLK_IE_BIT];
				if (!pwdata_i[UVD_RF_BIT] && s_reg.st != ST_UVD_RESET) begin
					s_next.uvd_rf = 1'b0;
				end
				if (!pwdata_i[WDG_RF_BIT] && s_reg.st == ST_RUN) begin
					s_next.wdg_rf = 1'b0;
				end
			end
			// pending warning: set beats service-entry clear
			if (warn_isr_enter_i) begin
				s_next.warn_pend = 1'b0;
			end
			if (s_reg.warn_ie && s_reg.st == ST_RUN && warn_raw != s_reg.warn_flag) begin
				s_next.warn_pend = 1'b1;
			end
			if (wr && hit_ics && pwdata_i[WARN_IE_BIT] && !s_reg.warn_ie
				&& s_reg.warn_flag) begin
				s_next.warn_pend = 1'b1;
			end
			if (!guard_en) begin
				s_next.backup_flag = 1'b0;
			end else if (s_reg.backup_sel) begin
				s_next.backup_flag = 1'b1;
			end else if (rd && hit_ics) begin
				s_next.backup_flag = 1'b0;
			end
		end
		// read data captured in the setup phase
		if (psel_i && !penable_i) begin
			s_next.rdata = hit_ics ? ics_val : (hit_opt ? opt_val : 8'h00);
			s_next.rd_err = !(hit_ics || hit_opt);
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '{st: ST_UVD_RESET, cnt: '0, src_sel: ICS_RESET[SRC_SEL_BIT],
				warn_ie: ICS_RESET[WARN_IE_BIT], warn_flag: ICS_RESET[WARN_FLAG_BIT],
				uvd_rf: ICS_RESET[UVD_RF_BIT], clk_ie: ICS_RESET[CLK_IE_BIT],
				backup_flag: ICS_RESET[BACKUP_FLAG_BIT], wdg_rf: ICS_RESET[WDG_RF_BIT],
				backup_sel: 1'b0, warn_pend: 1'b0, rdata: 8'h00, rd_err: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ============================================================
	// outputs
	assign rst_line_o = 1'b0;
	assign rst_line_oe_o = (s_reg.st != ST_RUN);
	assign uvd_level_o = sy[SY_LVL +: 2];
	assign glitch_filter_en_o = guard_en && sy[SY_PLL];
	assign backup_osc_en_o = guard_en && !cpu_halt_i;
	assign cpu_clk_backup_o = s_reg.backup_sel;
	assign warn_req = s_reg.warn_pend;
	assign clk_req = s_reg.clk_ie && s_reg.backup_flag && guard_en;
	assign warn_irq_o = warn_req && !irq_mask_i;
	assign clk_fail_irq_o = clk_req && !irq_mask_i;
	assign wake_o = cpu_wait_i && !cpu_halt_i && (warn_irq_o || clk_fail_irq_o);
	assign prdata_o = {24'h000000, s_reg.rdata};
	assign pready_o = psel_i && penable_i;
	assign pslverr_o = psel_i && penable_i && s_reg.rd_err;

	// ============================================================
	// assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	uvd_drives_line_a: assert property (uvd_trip |=> rst_line_oe_o)
		else $error("reset line not driven on undervoltage");

	wdg_pulse_len_a: assert property (
		(s_reg.st == ST_RUN && !uvd_trip && wdg_underflow_i) |=> rst_line_oe_o [*8])
		else $error("watchdog reset pulse too short");

	wdg_pulse_end_a: assert property (
		(s_reg.st == ST_WDG_RESET && s_next.st == ST_DELAY)
		|-> s_reg.cnt == CNT_W'(RST_OUT_CYC - 1))
		else $error("watchdog reset pulse length wrong");

	wdg_ignored_a: assert property (
		(s_reg.st == ST_DELAY || s_reg.st == ST_UVD_RESET) |=> s_reg.st != ST_WDG_RESET)
		else $error("watchdog reset outside run");

	delay_end_a: assert property (
		(s_reg.st == ST_DELAY && s_next.st == ST_RUN) |-> s_reg.cnt == delay_cyc - CNT_W'(1))
		else $error("reset delay length wrong");

	uvd_held_low_a: assert property ((s_reg.st == ST_UVD_RESET)
		|-> rst_line_oe_o && !rst_line_o)
		else $error("line released during undervoltage reset");

	uvd_flags_a: assert property ((s_reg.st == ST_UVD_RESET && uvd_trip)
		|=> s_reg.uvd_rf && !s_reg.wdg_rf)
		else $error("undervoltage reset flags wrong");

	wdg_flag_set_a: assert property ((s_reg.st == ST_WDG_RESET) |=> s_reg.wdg_rf)
		else $error("watchdog reset flag not set");

	warn_disabled_a: assert property (!uvd_en && !cpu_halt_i |=> !s_reg.warn_flag)
		else $error("warning flag set with detector disabled");

	toggle_irq_a: assert property (
		(s_reg.st == ST_RUN && s_reg.warn_ie && !cpu_halt_i
		&& warn_raw != s_reg.warn_flag) |=> s_reg.warn_pend)
		else $error("flag toggle raised no interrupt");

	no_irq_delay_a: assert property ((s_reg.st != ST_RUN && !s_reg.warn_pend
		&& !(wr && hit_ics)) |=> !s_reg.warn_pend)
		else $error("warning interrupt during reset delay");

	isr_clear_a: assert property ((warn_isr_enter_i && !cpu_halt_i
		&& !(wr && hit_ics)
		&& !(s_reg.st == ST_RUN && s_reg.warn_ie && warn_raw != s_reg.warn_flag))
		|=> !s_reg.warn_pend)
		else $error("pending warning not cleared");

	backup_sw_a: assert property ((guard_en && !cpu_halt_i && sy[SY_OSC_LOST])
		|=> cpu_clk_backup_o ##1 (s_reg.backup_flag || cpu_halt_i))
		else $error("backup clock not selected");

	read_clear_a: assert property (
		(rd && hit_ics && !s_reg.backup_sel && !cpu_halt_i) |=> !s_reg.backup_flag)
		else $error("backup flag not cleared by read");

	halt_freeze_a: assert property (cpu_halt_i |=> $stable(s_reg.warn_ie)
		&& $stable(s_reg.warn_flag) && $stable(s_reg.src_sel))
		else $error("register changed in halt");

	halt_clk_off_a: assert property (cpu_halt_i |=> !cpu_clk_backup_o)
		else $error("backup clock selected in halt");

	mask_gate_a: assert property (irq_mask_i |-> !warn_irq_o && !clk_fail_irq_o)
		else $error("interrupt passed global mask");
endmodule : system_integrity_monitor
`default_nettype wire

// ==== verification/reset_line_board.sv ====
// board model of the shared open-drain reset line with pull-up
`timescale 1ns/100ps
`default_nettype none
module reset_line_board (
	input wire logic drive_oe_i,
	input wire logic drive_val_i,
	input wire logic ext_pull_i,
	output logic line_o
);
	// ============================================================
	// wired-and of all pull-downs, pull-up otherwise
	assign line_o = ((drive_oe_i && !drive_val_i) || ext_pull_i) ? 1'b0 : 1'b1;
endmodule : reset_line_board
`default_nettype wire

// ==== verification/system_integrity_monitor_bench.sv ====
// self-checking bench of the system integrity monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module system_integrity_monitor_bench
	import integrity_pkg::*;
;
	typedef struct packed {logic rd; logic [31:0] dat; logic err;} note_t;
	note_t notes[$];
	note_t nt;
	int bad_count = 0;
	int n_compared = 0;
	int n;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, line_o, oe, bosc_en, clk_bk, gf_en, wirq, cirq, wake, line;
	logic below_rise = 1'b0;
	logic below_fall = 1'b0;
	logic warn_supply = 1'b0;
	logic warn_sense = 1'b0;
	logic osc_lost = 1'b0;
	logic wdg = 1'b0;
	logic cpu_wait = 1'b0;
	logic cpu_halt = 1'b0;
	logic isr = 1'b0;
	logic irq_mask = 1'b0;
	logic ext_pull = 1'b0;
	logic pll = 1'b0;
	logic long_dly = 1'b0;
	logic uvd_on = 1'b1;
	logic [1:0] lvl = 2'h0;
	logic [1:0] uvd_level;
	// ============================================================
	// clock, design and board
	always #25 clk = !clk;
	system_integrity_monitor i_dut (.clk_sys_i(clk), .srst_i(srst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .below_rise_i(below_rise),
		.below_fall_i(below_fall), .warn_supply_i(warn_supply), .warn_sense_i(warn_sense),
		.osc_lost_i(osc_lost), .opt_uvd_enable_i(uvd_on), .opt_long_delay_i(long_dly),
		.opt_pll_enable_i(pll), .opt_guard_enable_i(1'b1), .opt_uvd_level_i(lvl),
		.wdg_underflow_i(wdg), .cpu_wait_i(cpu_wait), .cpu_halt_i(cpu_halt),
		.warn_isr_enter_i(isr), .irq_mask_i(irq_mask), .rst_line_i(line), .rst_line_o(line_o),
		.rst_line_oe_o(oe), .uvd_level_o(uvd_level), .backup_osc_en_o(bosc_en),
		.cpu_clk_backup_o(clk_bk), .glitch_filter_en_o(gf_en), .warn_irq_o(wirq),
		.clk_fail_irq_o(cirq), .wake_o(wake));
	reset_line_board i_board (.drive_oe_i(oe), .drive_val_i(line_o), .ext_pull_i(ext_pull),
		.line_o(line));
	// ============================================================
	// apb master, notes the expected answer first
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ex, input logic er);
		notes.push_back({!wr, ex, er});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// hold the request until pready is seen high at an edge
		do begin
			@(posedge clk);
		end while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following setup never re-drives psel in this step
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0, ex, 1'b0);
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask : settle
	task automatic isr_pulse();
		isr <= 1'b1;
		@(posedge clk);
		isr <= 1'b0;
		settle();
	endtask : isr_pulse
	// counts edges until the reset line is released
	task automatic wait_free();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (oe && n < 6000);
	endtask : wait_free
	// ============================================================
	// answer watcher, oldest note against each completed transfer
	always @(posedge clk) begin
		if (psel && penable && pready) begin
			nt = notes.pop_front();
			if (nt.rd) `CHK("prdata", nt.dat, prdata)
			`CHK("pslverr", nt.err, pslverr)
		end
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		close_out();
	end
	// ============================================================
	// main sequence
	initial begin
		void'($urandom(61));
		pll <= 1'($urandom);
		lvl <= 2'($urandom);
		long_dly <= 1'($urandom);
		repeat (8) @(posedge clk);
		`CHK("oe_rst", 1'b1, oe)
		srst <= 1'b0;
		wait_free();
		rd(ICS_OFFSET, 32'h00);
		rd(OPT_OFFSET, {25'h0, 1'b1, lvl, 1'b1, pll, long_dly, 1'b1});
		// line level passes the synchroniser before the setup edge captures it
		ext_pull <= 1'b1;
		settle();
		rd(OPT_OFFSET, {25'h0, 1'b0, lvl, 1'b1, pll, long_dly, 1'b1});
		ext_pull <= 1'b0;
		`CHK("level", lvl, uvd_level)
		`CHK("filter", pll, gf_en)
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h00c, $urandom, 32'h0, 1'b1);
		$display("test setup done");
		warn_supply <= 1'b1;
		settle();
		rd(ICS_OFFSET, 32'h20);
		wr(ICS_OFFSET, 32'h40);
		settle();
		`CHK("warn_irq", 1'b1, wirq)
		cpu_wait <= 1'b1;
		irq_mask <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("masked", 1'b0, wirq)
		irq_mask <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("wake", 1'b1, wake)
		cpu_wait <= 1'b0;
		isr_pulse();
		`CHK("warn_clr", 1'b0, wirq)
		warn_supply <= 1'b0;
		settle();
		`CHK("warn_rise", 1'b1, wirq)
		rd(ICS_OFFSET, 32'h40);
		isr_pulse();
		wr(ICS_OFFSET, 32'hc0);
		warn_sense <= 1'b1;
		settle();
		`CHK("sense_fall", 1'b1, wirq)
		rd(ICS_OFFSET, 32'he0);
		isr_pulse();
		warn_sense <= 1'b0;
		settle();
		`CHK("sense_rise", 1'b1, wirq)
		isr_pulse();
		wr(ICS_OFFSET, 32'h04);
		$display("test warning done");
		osc_lost <= 1'b1;
		settle();
		`CHK("backup", 1'b1, clk_bk)
		`CHK("clk_irq", 1'b1, cirq)
		rd(ICS_OFFSET, 32'h06);
		osc_lost <= 1'b0;
		settle();
		`CHK("main_back", 1'b0, clk_bk)
		rd(ICS_OFFSET, 32'h06);
		rd(ICS_OFFSET, 32'h04);
		cpu_halt <= 1'b1;
		settle();
		`CHK("halt_osc", 1'b0, bosc_en)
		wr(ICS_OFFSET, 32'h00);
		cpu_halt <= 1'b0;
		settle();
		rd(ICS_OFFSET, 32'h04);
		wr(ICS_OFFSET, 32'h00);
		$display("test guard done");
		wdg <= 1'b1;
		@(posedge clk);
		wdg <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		`CHK("wdg_oe", 1'b1, oe)
		wait_free();
		`CHK("wdg_len", 1'b1, n >= RST_OUT_CYC)
		rd(ICS_OFFSET, 32'h01);
		$display("test watchdog done");
		wr(ICS_OFFSET, 32'h41);
		below_rise <= 1'b1;
		below_fall <= 1'b1;
		repeat (60) @(posedge clk);
		`CHK("uv_oe", 1'b1, oe)
		`CHK("uv_line", 1'b0, line)
		// warning toggles only while the line is held: fast rise, no interrupt
		warn_supply <= 1'b1;
		settle();
		warn_supply <= 1'b0;
		below_fall <= 1'b0;
		below_rise <= 1'b0;
		wait_free();
		settle();
		`CHK("delay_quiet", 1'b0, wirq)
		rd(ICS_OFFSET, 32'h50);
		wr(ICS_OFFSET, 32'h00);
		rd(ICS_OFFSET, 32'h00);
		$display("test undervoltage done");
		uvd_on <= 1'b0;
		warn_supply <= 1'b1;
		settle();
		rd(ICS_OFFSET, 32'h00);
		rd(OPT_OFFSET, {25'h0, 1'b1, lvl, 1'b1, pll, long_dly, 1'b0});
		warn_supply <= 1'b0;
		$display("test disable done");
		close_out();
	end
endmodule : system_integrity_monitor_bench
`default_nettype wire
